// [pkg/swq_defines.svh]
// Register offsets, field positions, reset values and timing counts of the global QoS block
`ifndef SWQ_DEFINES_SVH
`define SWQ_DEFINES_SVH

// Register offsets
`define SWQ_ADDR_PRIO_SNIFF   8'h05
`define SWQ_ADDR_MII_STORM    8'h06
`define SWQ_ADDR_STORM_LOW    8'h07

// Priority and sniff register fields
`define SWQ_BIT_SNIFF_BOTH    0
`define SWQ_PRIO_LSB          2
`define SWQ_PRIO_MSB          3

// Switch MII and storm high register fields
`define SWQ_BIT_BACKPRESSURE  7
`define SWQ_BIT_HALF_DUPLEX   6
`define SWQ_BIT_FLOW_CTRL     5
`define SWQ_BIT_SPEED_10      4
`define SWQ_BIT_NULL_VID      3
`define SWQ_STORM_HI_MSB      2

// Reset values
`define SWQ_RST_PRIO_SNIFF    8'h00
`define SWQ_RST_MII_STORM     8'h00
`define SWQ_RST_STORM_LOW     8'h4a

// High to low interleave ratios
`define SWQ_RATIO_10          4'ha
`define SWQ_RATIO_5           4'h5
`define SWQ_RATIO_2           4'h2

// Timing
`define SWQ_CLK_PERIOD_NS     20
`define SWQ_PERIOD_100_MS     50
`define SWQ_PERIOD_10_MS      500
`define SWQ_PERIOD_100_CYC    (`SWQ_PERIOD_100_MS * 1000000 / `SWQ_CLK_PERIOD_NS)
`define SWQ_PERIOD_10_RATIO   (`SWQ_PERIOD_10_MS / `SWQ_PERIOD_100_MS)
`define SWQ_STRAP_SETTLE      3'h5

`endif

// [pkg/swq_pkg.sv]
// Types shared by the global QoS, MII and storm control block
package swq_pkg;
	// Egress priority scheme codes
	typedef enum logic [1:0] {
		SWQ_STRICT,
		SWQ_RATIO10,
		SWQ_RATIO5,
		SWQ_RATIO2
	} swq_prio_e;

	typedef logic [10:0] swq_rate_t;   // Storm limit in 64-byte blocks
	typedef logic [11:0] swq_vid_t;    // VLAN ID
	typedef logic [7:0]  swq_byte_t;   // Register byte
endpackage

// [rtl/swq_strap_sync.sv]
// Strap pin synchroniser that hands one settled snapshot to the register bank
`timescale 1ns/1ns
`include "swq_defines.svh"
module swq_strap_sync #(
	parameter int W = 3
) (
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] strap_val,
	output logic              strap_load
);
	logic [W-1:0] sync1;    // First stage, read only by sync2
	logic [W-1:0] sync2;    // Second stage
	logic [W-1:0] sync3;    // Third stage
	logic [2:0]   settle;   // Cycles since reset release

	// The synchroniser needs at least one pin to carry
	if (W < 1)
		$error("W must be at least 1");

	////////////////////////////////////////////////////////////////////////////
	// Three-stage synchroniser
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end
		else
		begin
			sync1 <= pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Accept a level only once the last two stages agree
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			strap_val <= '0;
		else if (sync2 == sync3)
			strap_val <= sync3;
	end

	////////////////////////////////////////////////////////////////////////////
	// One load pulse once the pipeline has filled after release
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			settle     <= 3'h0;
			strap_load <= 1'b0;
		end
		else
		begin
			strap_load <= (settle == `SWQ_STRAP_SETTLE - 3'h1);
			if (settle != `SWQ_STRAP_SETTLE)
				settle <= settle + 3'h1;
		end
	end
endmodule

// [rtl/swq_storm_meter.sv]
// Per-port broadcast storm meter counting 64-byte blocks per period
`timescale 1ns/1ns
`include "swq_defines.svh"
module swq_storm_meter
	import swq_pkg::*;
#(
	parameter int PORTS      = 5,
	parameter int PERIOD_CYC = `SWQ_PERIOD_100_CYC
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  swq_pkg::swq_rate_t    limit,
	input  wire logic             mcast_excl,
	input  wire logic [PORTS-1:0] storm_en,
	input  wire logic [PORTS-1:0] speed_10,
	input  wire logic [PORTS-1:0] frm_start,
	input  wire logic [PORTS-1:0] frm_bcast,
	input  wire logic [PORTS-1:0] frm_mcast,
	input  wire logic [PORTS-1:0] blk,
	output logic      [PORTS-1:0] frm_drop
);
	logic [31:0]      tick_cnt;            // Base 50 ms period timer
	logic             tick;                // Base period boundary
	logic [3:0]       slow_cnt [PORTS];    // Base periods seen by a 10 Mbps port
	logic [11:0]      blocks   [PORTS];    // Saturating block count
	logic [PORTS-1:0] counting;            // Current frame is metered

	// The period timer must count at least two cycles per period
	if (PORTS < 1 || PERIOD_CYC < 2)
		$error("storm meter parameters out of range");

	////////////////////////////////////////////////////////////////////////////
	// Base period timer
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			tick_cnt <= 32'h0;
		else if (tick)
			tick_cnt <= 32'h0;
		else
			tick_cnt <= tick_cnt + 32'h1;
	end
	assign tick = (tick_cnt == 32'(PERIOD_CYC - 1));

	////////////////////////////////////////////////////////////////////////////
	// Per-port metering
	for (genvar p = 0; p < PORTS; p++)
	begin : g_port
		logic period_end;    // This port's period closes
		logic qualifies;     // Frame counts toward the storm limit
		logic over;          // Limit already reached in this period

		assign period_end = tick && (!speed_10[p] ||
			(slow_cnt[p] == 4'(`SWQ_PERIOD_10_RATIO - 1)));
		assign qualifies = storm_en[p] && (frm_bcast[p] ||
			(frm_mcast[p] && !mcast_excl));
		assign over = (blocks[p] >= {1'b0, limit});

		// Slow period divider for 10 Mbps ports
		always_ff @(posedge clock)
		begin
			if (!reset_n)
				slow_cnt[p] <= 4'h0;
			else if (tick)
				slow_cnt[p] <= period_end ? 4'h0 : slow_cnt[p] + 4'h1;
		end

		// Block counter, cleared at each period end
		always_ff @(posedge clock)
		begin
			if (!reset_n)
				blocks[p] <= 12'h0;
			else if (period_end)
				blocks[p] <= 12'h0;
			else if (blk[p] && counting[p] && !blocks[p][11])
				blocks[p] <= blocks[p] + 12'h1;
		end

		// Frame admission and drop decision
		always_ff @(posedge clock)
		begin
			if (!reset_n)
			begin
				counting[p] <= 1'b0;
				frm_drop[p] <= 1'b0;
			end
			else
			begin
				frm_drop[p] <= frm_start[p] && qualifies && over;
				if (frm_start[p])
					counting[p] <= qualifies && !over;
			end
		end
	end
endmodule

// [rtl/swq_top.sv]
// Global priority, sniff, switch MII and storm control register bank
// How it works
// - Two-bit code picks strict or weighted interleave.
// - Sniff bit set: mirror when both ports match.
// - Sniff bit clear: mirror when either matches.
// - Receive-only mirroring uses the either-match setting.
// - Bit 7 enables MII back pressure, resets zero.
// - Bit 6 selects MII half or full duplex.
// - Bit 5 enables MII pause flow control.
// - Bit 4 selects MII 10 or 100 Mbps.
// - Replace null VLAN ID with port default.
// - Storm period 50 ms fast, 500 ms slow.
// - Storm limit resets to 0x04a blocks.
// - Limit applies only to storm-enabled ports.
// - Multicast exclusion counts only broadcast frames.
`timescale 1ns/1ns
`include "swq_defines.svh"
module swq_top
	import swq_pkg::*;
#(
	parameter int PORTS      = 5,
	parameter int PERIOD_CYC = `SWQ_PERIOD_100_CYC
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	// Register port
	input  wire logic [7:0]       reg_addr,
	input  swq_pkg::swq_byte_t    reg_wdata,
	input  wire logic             reg_write,
	input  wire logic             reg_read,
	output swq_pkg::swq_byte_t    reg_rdata,
	// Strap pins
	input  wire logic             duplex_strap_pin,
	input  wire logic             flow_ctrl_strap_pin,
	input  wire logic             speed_strap_pin,
	// Switch MII settings
	output logic                  mii_backpressure_en,
	output logic                  mii_half_duplex,
	output logic                  mii_flow_ctrl_en,
	output logic                  mii_speed_10,
	// Egress scheduler slot
	input  wire logic             sched_take,
	input  wire logic             sched_hi_pend,
	input  wire logic             sched_lo_pend,
	output logic                  sched_grant_hi,
	output logic                  sched_grant_lo,
	// Mirror decision
	input  wire logic             mirror_req,
	input  wire logic             mirror_src_match,
	input  wire logic             mirror_dst_match,
	output logic                  mirror_valid,
	output logic                  mirror_hit,
	// Null VLAN ID replacement
	input  wire logic             vid_req,
	input  wire logic             vid_tagged,
	input  swq_pkg::swq_vid_t     vid_in,
	input  swq_pkg::swq_vid_t     vid_port_default,
	output logic                  vid_valid,
	output swq_pkg::swq_vid_t     vid_out,
	// Storm metering
	input  wire logic             storm_mcast_excl,
	input  wire logic [PORTS-1:0] storm_port_en,
	input  wire logic [PORTS-1:0] storm_port_speed_10,
	input  wire logic [PORTS-1:0] storm_frm_start,
	input  wire logic [PORTS-1:0] storm_frm_bcast,
	input  wire logic [PORTS-1:0] storm_frm_mcast,
	input  wire logic [PORTS-1:0] storm_blk,
	output logic      [PORTS-1:0] storm_frm_drop,
	output swq_pkg::swq_rate_t    storm_limit
);
	import swq_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	if (PORTS < 1 || PORTS > 32)
		$error("PORTS must lie between 1 and 32");
	if (PERIOD_CYC < 2)
		$error("PERIOD_CYC must be at least 2");

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	swq_byte_t  prio_sniff;     // Priority scheme and sniff mode
	swq_byte_t  mii_storm;      // Switch MII options and storm limit high bits
	swq_byte_t  storm_low;      // Storm limit low byte
	logic [2:0] strap_val;      // Settled strap levels: duplex, flow, speed
	logic       strap_load;     // One pulse after reset release
	swq_prio_e  prio_scheme;    // Current scheme
	logic [3:0] hi_run;         // High grants since last low grant
	logic       sniff_both;     // Sniff mode select

	// High grants allowed before a low one must go
	function automatic logic [3:0] hi_quota(input swq_prio_e scheme);
		unique case (scheme)
			SWQ_RATIO10: hi_quota = `SWQ_RATIO_10;
			SWQ_RATIO5:  hi_quota = `SWQ_RATIO_5;
			SWQ_RATIO2:  hi_quota = `SWQ_RATIO_2;
			SWQ_STRICT:  hi_quota = 4'hf;
		endcase
	endfunction

	// Write decode for one register
	function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target);
		wr_hit = reg_write && (addr == target);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Strap capture
	// The straps are taken once after reset; later pin changes are ignored,
	// so software owns the option bits from then on
	swq_strap_sync #(
		.W          (3)
	) u_strap (
		.clock      (clock),
		.reset_n    (reset_n),
		.pin_in     ({duplex_strap_pin, flow_ctrl_strap_pin, speed_strap_pin}),
		.strap_val  (strap_val),
		.strap_load (strap_load)
	);

	////////////////////////////////////////////////////////////////////////////
	// Priority and sniff register
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			prio_sniff <= `SWQ_RST_PRIO_SNIFF;
		else if (wr_hit(reg_addr, `SWQ_ADDR_PRIO_SNIFF))
			prio_sniff <= reg_wdata;
	end

	// Switch MII and storm high register
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			mii_storm <= `SWQ_RST_MII_STORM;
		else if (wr_hit(reg_addr, `SWQ_ADDR_MII_STORM))
			mii_storm <= reg_wdata;
		else if (strap_load)
		begin
			// Straps fill the option bits unless software writes the register in the same cycle
			mii_storm[`SWQ_BIT_HALF_DUPLEX] <= strap_val[2];
			mii_storm[`SWQ_BIT_FLOW_CTRL]   <= strap_val[1];
			mii_storm[`SWQ_BIT_SPEED_10]    <= strap_val[0];
		end
	end

	// Storm limit low byte
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			storm_low <= `SWQ_RST_STORM_LOW;
		else if (wr_hit(reg_addr, `SWQ_ADDR_STORM_LOW))
			storm_low <= reg_wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port: data stand only in the cycle after the strobe
	// Unmapped offsets read as zero, so a probe of the bank never returns
	// a stale value left over from an earlier read
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (reg_read)
		begin
			unique case (reg_addr)
				`SWQ_ADDR_PRIO_SNIFF: reg_rdata <= prio_sniff;
				`SWQ_ADDR_MII_STORM:  reg_rdata <= mii_storm;
				`SWQ_ADDR_STORM_LOW:  reg_rdata <= storm_low;
				default:              reg_rdata <= 8'h00;    // Unmapped
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// Field outputs
	// Option bits are wired straight out of the register with no extra delay
	assign mii_backpressure_en = mii_storm[`SWQ_BIT_BACKPRESSURE];
	assign mii_half_duplex     = mii_storm[`SWQ_BIT_HALF_DUPLEX];
	assign mii_flow_ctrl_en    = mii_storm[`SWQ_BIT_FLOW_CTRL];
	assign mii_speed_10        = mii_storm[`SWQ_BIT_SPEED_10];
	assign storm_limit = {mii_storm[`SWQ_STORM_HI_MSB:0], storm_low};
	assign prio_scheme = swq_prio_e'(prio_sniff[`SWQ_PRIO_MSB:`SWQ_PRIO_LSB]);
	assign sniff_both  = prio_sniff[`SWQ_BIT_SNIFF_BOTH];

	////////////////////////////////////////////////////////////////////////////
	// Egress scheduler grant
	// The run counter is kept across scheme changes; a switch to a smaller quota
	// therefore lets one low packet out at once, which only shortens a high run.
	// Strict mode holds the counter at zero so a later ratio scheme starts afresh.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			sched_grant_hi <= 1'b0;
			sched_grant_lo <= 1'b0;
			hi_run         <= 4'h0;
		end
		else
		begin
			sched_grant_hi <= 1'b0;
			sched_grant_lo <= 1'b0;
			if (sched_take)
			begin
				if (prio_scheme == SWQ_STRICT)
				begin
					// High always goes first
					sched_grant_hi <= sched_hi_pend;
					sched_grant_lo <= !sched_hi_pend && sched_lo_pend;
					hi_run         <= 4'h0;
				end
				else if (sched_hi_pend &&
					(!sched_lo_pend || hi_run < hi_quota(prio_scheme)))
				begin
					// High within its quota
					sched_grant_hi <= 1'b1;
					if (hi_run != 4'hf)
						hi_run <= hi_run + 4'h1;
				end
				else if (sched_lo_pend)
				begin
					// Quota used up: one low packet
					sched_grant_lo <= 1'b1;
					hi_run         <= 4'h0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mirror decision
	// The match flags arrive with the request and are judged in that cycle;
	// the hit flag is forced low between answers so it never outlives its valid
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			mirror_valid <= 1'b0;
			mirror_hit   <= 1'b0;
		end
		else
		begin
			mirror_valid <= mirror_req;
			if (!mirror_req)
				mirror_hit <= 1'b0;
			else if (sniff_both)
				mirror_hit <= mirror_src_match && mirror_dst_match;
			else
				mirror_hit <= mirror_src_match || mirror_dst_match;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Null VLAN ID replacement
	// Only tagged frames carry an ID to replace; untagged ones pass as they are.
	// The output keeps its value between requests for the egress path to read.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			vid_valid <= 1'b0;
			vid_out   <= 12'h000;
		end
		else
		begin
			vid_valid <= vid_req;
			if (vid_req)
			begin
				if (mii_storm[`SWQ_BIT_NULL_VID] && vid_tagged && vid_in == 12'h000)
					vid_out <= vid_port_default;
				else
					vid_out <= vid_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Broadcast storm meter
	// The limit is taken live from the registers, so a rewrite takes effect at
	// the next frame start without waiting for the period to close
	swq_storm_meter #(
		.PORTS      (PORTS),
		.PERIOD_CYC (PERIOD_CYC)
	) u_storm (
		.clock      (clock),
		.reset_n    (reset_n),
		.limit      (storm_limit),
		.mcast_excl (storm_mcast_excl),
		.storm_en   (storm_port_en),
		.speed_10   (storm_port_speed_10),
		.frm_start  (storm_frm_start),
		.frm_bcast  (storm_frm_bcast),
		.frm_mcast  (storm_frm_mcast),
		.blk        (storm_blk),
		.frm_drop   (storm_frm_drop)
	);
endmodule

// [tb/swq_mii_peer.sv]
// Strap side of the external MAC or PHY on the switch MII
`timescale 1ns/1ns
module swq_mii_peer (
	input  wire logic       drive_en,
	input  wire logic [2:0] drive_val,
	output logic            duplex_strap_pin,
	output logic            flow_ctrl_strap_pin,
	output logic            speed_strap_pin
);
	////////////////////////////////////////////////////////////////
	// Undriven pins fall to the internal pull-down level
	assign duplex_strap_pin    = drive_en ? drive_val[2] : 1'b0;
	assign flow_ctrl_strap_pin = drive_en ? drive_val[1] : 1'b0;
	assign speed_strap_pin     = drive_en ? drive_val[0] : 1'b0;
endmodule

// [tb/swq_top_assertions.sv]
// Concurrent checks on the ports of the register bank
`timescale 1ns/1ns
module swq_top_assertions
	import swq_pkg::*;
#(
	parameter int PORTS = 5
) (
	input wire logic             clock,
	input wire logic             reset_n,
	input wire logic [7:0]       reg_addr,
	input swq_pkg::swq_byte_t    reg_wdata,
	input wire logic             reg_write,
	input wire logic             reg_read,
	input swq_pkg::swq_byte_t    reg_rdata,
	input wire logic             mii_backpressure_en,
	input wire logic             mii_half_duplex,
	input wire logic             mii_flow_ctrl_en,
	input wire logic             mii_speed_10,
	input wire logic             sched_take,
	input wire logic             sched_grant_hi,
	input wire logic             sched_grant_lo,
	input wire logic             mirror_req,
	input wire logic             mirror_valid,
	input wire logic             mirror_hit,
	input wire logic             vid_req,
	input wire logic             vid_valid,
	input wire logic [PORTS-1:0] storm_port_en,
	input wire logic [PORTS-1:0] storm_frm_start,
	input wire logic [PORTS-1:0] storm_frm_drop,
	input swq_pkg::swq_rate_t    storm_limit
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////
	// Register port
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside read answer");
	a_rdata_low: assert property ($past(reg_read && reg_addr == 8'h07)
		|-> reg_rdata == $past(storm_limit[7:0])) else $error("low limit byte misread");
	a_limit_write: assert property ($past(reg_write && reg_addr == 8'h07)
		|-> storm_limit[7:0] == $past(reg_wdata)) else $error("low limit byte not written");
	a_mii_write: assert property ($past(reg_write && reg_addr == 8'h06)
		|-> {mii_backpressure_en, mii_half_duplex, mii_flow_ctrl_en, mii_speed_10,
		storm_limit[10:8]} == {$past(reg_wdata[7:4]), $past(reg_wdata[2:0])})
		else $error("MII or limit high bits not written");
	////////////////////////////////////////////////////////////////
	// Scheduler, mirror, VLAN and storm answers
	a_grant_cause: assert property ((sched_grant_hi || sched_grant_lo) |-> $past(sched_take))
		else $error("grant without take");
	a_grant_single: assert property (!(sched_grant_hi && sched_grant_lo))
		else $error("two grants at once");
	a_mirror_timing: assert property (mirror_valid == $past(mirror_req))
		else $error("mirror answer misplaced");
	a_hit_valid: assert property (mirror_hit |-> mirror_valid)
		else $error("hit without valid");
	a_vid_timing: assert property (vid_valid == $past(vid_req))
		else $error("VLAN answer misplaced");
	a_drop_cause: assert property (storm_frm_drop != 0
		|-> (storm_frm_drop & ~$past(storm_frm_start & storm_port_en)) == 0)
		else $error("drop on idle or unprotected port");
	// Main scenarios
	c_hit: cover property (mirror_hit);
	c_low: cover property (sched_grant_lo);
	c_drop: cover property (storm_frm_drop != 0);
endmodule
bind swq_top swq_top_assertions #(.PORTS(PORTS)) chk_i (
	.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.mii_backpressure_en(mii_backpressure_en), .mii_half_duplex(mii_half_duplex),
	.mii_flow_ctrl_en(mii_flow_ctrl_en), .mii_speed_10(mii_speed_10),
	.sched_take(sched_take), .sched_grant_hi(sched_grant_hi),
	.sched_grant_lo(sched_grant_lo), .mirror_req(mirror_req),
	.mirror_valid(mirror_valid), .mirror_hit(mirror_hit), .vid_req(vid_req),
	.vid_valid(vid_valid), .storm_port_en(storm_port_en),
	.storm_frm_start(storm_frm_start), .storm_frm_drop(storm_frm_drop),
	.storm_limit(storm_limit));

// [tb/swq_top_tb.sv]
// Self-checking bench for the global QoS, MII and storm register bank
`timescale 1ns/1ns
module swq_top_tb;
	import swq_pkg::*;
	localparam int PER = 200; // Shortened storm period
	logic clock = 0, reset_n = 0, reg_write = 0, reg_read = 0, rd_d = 0;
	logic [7:0] reg_addr = 0, d, e;
	swq_byte_t reg_wdata = 0, reg_rdata;
	swq_byte_t exp_q[$]; // Expected read data
	logic s_en = 0, p_dup, p_flo, p_spd; // Strap drive and pins
	logic [2:0] s_val = 0;
	logic [3:0] mii; // MII settings
	logic take = 0, hp = 1, lp = 1, g_hi, g_lo, m_req = 0, m_src = 0, m_dst = 0, m_v, m_h;
	logic v_req = 0, v_tag = 1, v_v, excl = 1;
	swq_vid_t v_in = 0, v_def = 0, v_out;
	logic [4:0] s_pen = 5'h03, s_p10 = 5'h02, s_st = 0, s_bc = 0, s_mc = 0, s_blk = 0, s_drop;
	swq_rate_t s_lim;
	int n_mismatch = 0, total_checks = 0, seed = 32'hfc42, n;
	////////////////////////////////////////////////////////////////
	swq_top #(.PORTS(5), .PERIOD_CYC(PER)) dut (
		.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.duplex_strap_pin(p_dup), .flow_ctrl_strap_pin(p_flo), .speed_strap_pin(p_spd),
		.mii_backpressure_en(mii[3]), .mii_half_duplex(mii[2]), .mii_flow_ctrl_en(mii[1]),
		.mii_speed_10(mii[0]), .sched_take(take), .sched_hi_pend(hp), .sched_lo_pend(lp),
		.sched_grant_hi(g_hi), .sched_grant_lo(g_lo), .mirror_req(m_req),
		.mirror_src_match(m_src), .mirror_dst_match(m_dst), .mirror_valid(m_v),
		.mirror_hit(m_h), .vid_req(v_req), .vid_tagged(v_tag), .vid_in(v_in),
		.vid_port_default(v_def), .vid_valid(v_v), .vid_out(v_out),
		.storm_mcast_excl(excl), .storm_port_en(s_pen), .storm_port_speed_10(s_p10),
		.storm_frm_start(s_st), .storm_frm_bcast(s_bc), .storm_frm_mcast(s_mc),
		.storm_blk(s_blk), .storm_frm_drop(s_drop), .storm_limit(s_lim));
	swq_mii_peer peer (.drive_en(s_en), .drive_val(s_val), .duplex_strap_pin(p_dup),
		.flow_ctrl_strap_pin(p_flo), .speed_strap_pin(p_spd));
	////////////////////////////////////////////////////////////////
	// Clock and comparison helpers
	initial
	begin
		forever #10 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Register port master, reset and request tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		exp_q.push_back(v);
		@(posedge clock);
		reg_read <= 1'b0;
	endtask
	task automatic rst();
		reset_n <= 1'b0;
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
	task automatic tk(input logic hi);
		@(posedge clock);
		take <= 1'b1;
		@(posedge clock);
		take <= 1'b0;
		@(negedge clock);
		chk("grant", {g_hi, g_lo}, {hi, !hi});
	endtask
	task automatic frm(input int p, input logic bc, input logic drop, input logic blk);
		@(posedge clock);
		s_st[p] <= 1'b1;
		s_bc[p] <= bc;
		s_mc[p] <= !bc;
		@(posedge clock);
		s_st[p] <= 1'b0;
		s_blk[p] <= blk;
		@(negedge clock);
		chk("drop", s_drop[p], drop);
		@(posedge clock);
		s_blk[p] <= 1'b0;
	endtask
	// Read answers are compared one cycle after each taken read
	always @(posedge clock) rd_d <= reg_read;
	always @(negedge clock)
	begin
		if (rd_d)
			chk("rdata", reg_rdata, exp_q.pop_front());
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst();
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h4a);
		rd(8'h08, 8'h00);
		chk("limit", s_lim, 11'h04a);
		s_en <= 1'b1;
		s_val <= 3'h6;
		rst();
		rd(8'h06, 8'h60);
		chk("mii", mii, 4'h6);
		repeat (4)
		begin
			d = $random(seed);
			e = $random(seed);
			wr(8'h06, d);
			wr(8'h07, e);
			rd(8'h06, d);
			@(negedge clock);
			chk("mii", mii, d[7:4]);
			chk("limit", s_lim, {d[2:0], e});
		end
		$display("Test registers done");
		for (int s = 0; s < 8; s++)
		begin
			wr(8'h05, 8'(s[2]));
			@(posedge clock);
			m_req <= 1'b1;
			m_src <= s[1];
			m_dst <= s[0];
			@(posedge clock);
			m_req <= 1'b0;
			@(negedge clock);
			chk("mirror", {m_v, m_h}, {1'b1, s[2] ? &s[1:0] : |s[1:0]});
		end
		wr(8'h05, 8'h00);
		repeat (12) tk(1'b1);
		@(posedge clock);
		hp <= 1'b0;
		tk(1'b0);
		@(posedge clock);
		hp <= 1'b1;
		for (int c = 1; c < 4; c++)
		begin
			n = (c == 1) ? 10 : (c == 2) ? 5 : 2;
			wr(8'h05, 8'(c << 2));
			for (int k = 0; k <= n; k++) tk(k < n);
		end
		$display("Test mirror and scheduler done");
		for (int en = 0; en < 3; en++)
		begin
			wr(8'h06, en ? 8'h08 : 8'h00);
			@(posedge clock);
			v_req <= 1'b1;
			v_in <= (en == 2) ? 12'h5a3 : 12'h000;
			v_def <= 12'($random(seed)) | 12'h001;
			@(posedge clock);
			v_req <= 1'b0;
			@(negedge clock);
			chk("vid", {v_v, v_out}, {1'b1, (en == 1) ? v_def : v_in});
		end
		s_en <= 1'b0;
		rst();
		wr(8'h07, 8'h01);
		frm(0, 1'b1, 1'b0, 1'b1);
		frm(0, 1'b1, 1'b1, 1'b0);
		frm(0, 1'b0, 1'b0, 1'b0);
		excl <= 1'b0;
		frm(0, 1'b0, 1'b1, 1'b0);
		excl <= 1'b1;
		frm(2, 1'b1, 1'b0, 1'b1);
		frm(2, 1'b1, 1'b0, 1'b0);
		frm(1, 1'b1, 1'b0, 1'b1);
		frm(1, 1'b1, 1'b1, 1'b0);
		repeat (PER + 20) @(posedge clock);
		frm(0, 1'b1, 1'b0, 1'b0);
		frm(1, 1'b1, 1'b1, 1'b0);
		$display("Test storm done");
		repeat (4) @(posedge clock);
		complete_run();
	end
	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		complete_run();
	end
endmodule
